/* File: hdl/qdsr_top.sv */
`timescale 1ns/1ps
// Quad dynamic serial shift register
module qdsr_top #(
  parameter int LEN = qdsr_pkg::LEN_LONG
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       shift_clk,
  input  wire logic [3:0] ser_in,
  input  wire logic [3:0] recirc,
  input  wire logic       out_ready,
  output logic      [3:0] ser_out,
  output logic            out_valid,
  output logic            stall
);
  localparam int N = qdsr_pkg::LANES;

  qdsr_stream_if #(.W(N)) lane_s ();

  logic            sclk_q, ph1_q;
  logic            fall;
  logic [LEN-1:0]  lane_q [N];
  logic [N-1:0]    tail;
  logic [N-1:0]    bout_data;
  logic            bout_valid;
  logic [N-1:0]    ser_out_q;
  logic            out_valid_q, stall_q;

  // Phase one samples the outside clock; a falling edge is phase two
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sclk_q <= 1'b0;
    else        sclk_q <= shift_clk;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ph1_q <= 1'b0;
    else        ph1_q <= sclk_q;
  end
  assign fall = ph1_q && !sclk_q;

  // Shift only while the buffer can take the emitted word
  assign lane_s.valid = fall;

  // One lane per generate entry, own recirc select, shared shift enable
  for (genvar g = 0; g < N; g++) begin : g_lane
    assign tail[g] = lane_q[g][LEN-1];
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        lane_q[g] <= '0;
      end else if (fall && lane_s.ready) begin
        // Head takes recirculated bit or new data
        lane_q[g] <= {lane_q[g][LEN-2:0],
                      recirc[g] ? tail[g] : ser_in[g]};
      end
    end
  end
  assign lane_s.data = tail;

  qdsr_buf #(.W(N), .DEPTH(qdsr_pkg::BUF_DEPTH)) u_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_s      (lane_s),
    .out_valid (bout_valid),
    .out_data  (bout_data),
    .out_ready (out_ready)
  );

  // Registered outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_out_q   <= '0;
      out_valid_q <= 1'b0;
      stall_q     <= 1'b0;
    end else begin
      if (bout_valid && out_ready) ser_out_q <= bout_data;
      out_valid_q <= bout_valid && out_ready;
      stall_q     <= fall && !lane_s.ready;
    end
  end
  assign ser_out   = ser_out_q;
  assign out_valid = out_valid_q;
  assign stall     = stall_q;

  a_shift_head: assert property (@(posedge clk) disable iff (!rst_b)
    fall && lane_s.ready && !recirc[0] |=> lane_q[0][0] == $past(ser_in[0]))
    else $error("head not loaded from input");
  a_recirc_head: assert property (@(posedge clk) disable iff (!rst_b)
    fall && lane_s.ready && recirc[1] |=> lane_q[1][0] == $past(tail[1]))
    else $error("head not recirculated");
  a_hold_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !(fall && lane_s.ready) |=> lane_q[2] == $past(lane_q[2]))
    else $error("lane moved without edge");
  a_fall_edge: assert property (@(posedge clk) disable iff (!rst_b)
    fall |-> $past(shift_clk, 2) && !$past(shift_clk))
    else $error("bad phase detect");
  a_len_delay: assert property (@(posedge clk) disable iff (!rst_b)
    fall && lane_s.ready |=> lane_q[3][LEN-1] == $past(lane_q[3][LEN-2]))
    else $error("lane length wrong");
  c_recirc: cover property (@(posedge clk) fall && recirc[0]);
  c_load:   cover property (@(posedge clk) fall && !recirc[0]);
  c_stall:  cover property (@(posedge clk) fall && !lane_s.ready);
endmodule // qdsr_top

/* File: inc/qdsr_pkg.sv */
package qdsr_pkg;
  localparam int LANES       = 4;
  localparam int LEN_LONG    = 80;
  localparam int LEN_SHORT   = 64;
  localparam int BUF_DEPTH   = 2;
  localparam int FMIN_KHZ    = 10;
  localparam int FMAX_KHZ    = 5000;
  localparam logic RST_BIT   = 1'h0;
endpackage

/* File: inc/qdsr_stream_if.sv */
`timescale 1ns/1ps
// Word path from lane array into the output buffer
interface qdsr_stream_if #(parameter int W = 4);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: hdl/qdsr_buf.sv */
`timescale 1ns/1ps
// Two-entry buffer; holds words while the receiver stalls
module qdsr_buf #(
  parameter int W     = 4,
  parameter int DEPTH = qdsr_pkg::BUF_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  qdsr_stream_if.snk        in_s,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  logic [W-1:0] mem_q [DEPTH];
  logic [$clog2(DEPTH)-1:0] wp_q, rp_q;
  logic [$clog2(DEPTH):0]   cnt_q;
  logic push, pop;

  // Handshakes on both sides
  assign in_s.ready = (cnt_q != ($clog2(DEPTH)+1)'(DEPTH));
  assign push       = in_s.valid && in_s.ready;
  assign pop        = out_valid && out_ready;
  assign out_valid  = (cnt_q != '0);
  assign out_data   = mem_q[rp_q];

  // Storage writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else if (push) begin
      mem_q[wp_q] <= in_s.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop)  rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + ($clog2(DEPTH)+1)'(push)
                     - ($clog2(DEPTH)+1)'(pop);
    end
  end

  a_buf_no_over: assert property (@(posedge clk) disable iff (!rst_b)
    cnt_q <= ($clog2(DEPTH)+1)'(DEPTH))
    else $error("buffer overfilled");
endmodule // qdsr_buf

/* File: verif/qdsr_drv.sv */
`timescale 1ns/1ps
// Outside clock source; one low-then-high period per go pulse
module qdsr_drv (
  input  wire logic clk,
  input  wire logic go,
  output logic      shift_clk
);
  int n = 0;
  // Low for 4 clk, high for at least 5; idles high
  always @(negedge clk) begin
    if (go)
      n <= 8;
    else if (n > 0)
      n <= n - 1;
  end
  assign shift_clk = !(n > 4);
endmodule // qdsr_drv

/* File: verif/qdsr_top_bench.sv */
`timescale 1ns/1ps
module qdsr_top_bench;
  localparam int L = qdsr_pkg::LEN_SHORT;
  logic clk = 0, rst_b = 0, go = 0, out_ready = 1, sc, ov, st;
  logic [3:0] si = 4'h0, rc = 4'h0, so, nx, mdl [L] = '{default: 4'h0};
  logic [3:0] expq [$], gotq [$];
  int failures = 0, checks_done = 0, p = 0, stalls = 0;
  always #25 clk = ~clk;
  qdsr_drv u_qdsr_drv (.clk(clk), .go(go), .shift_clk(sc));
  qdsr_top #(.LEN(L)) u_qdsr_top (.clk(clk), .rst_b(rst_b), .shift_clk(sc),
    .ser_in(si), .recirc(rc), .out_ready(out_ready), .ser_out(so),
    .out_valid(ov), .stall(st));
  // Collect delivered words and dropped shifts
  always @(negedge clk) begin
    if (ov === 1'b1) gotq.push_back(so);
    if (st === 1'b1) stalls++;
  end
  task end_sim;
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [3:0] g, input logic [3:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task chk_n(input int g, input int e);
    checks_done++;
    if (g != e) begin
      failures++;
      $display("[ERR] %0t count %0d expected %0d", $time, g, e);
    end
  endtask
  // One shift; ring model commits only when not refused
  task shift(input logic [3:0] d, input logic [3:0] r);
    int s;
    s = stalls;
    @(negedge clk);
    si = d;
    rc = r;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    repeat (8) @(negedge clk);
    if (stalls == s) begin
      nx = mdl[p];
      expq.push_back(nx);
      mdl[p] = (r & nx) | (~r & d);
      p = (p + 1) % L;
    end
  endtask
  // Compare delivered words against the ring model, then clear
  task judge;
    repeat (20) @(negedge clk);
    chk_n(gotq.size(), expq.size());
    foreach (expq[i])
      if (i < gotq.size()) chk(gotq[i], expq[i]);
    gotq.delete();
    expq.delete();
  endtask
  task load_run;
    for (int k = 0; k < L; k++) shift(k[3:0] ^ k[5:2], 4'h0);
    judge;
  endtask
  task recirc_run;
    for (int k = 0; k < L; k++) shift(~k[3:0], 4'h5);
    for (int k = 0; k < L; k++) shift(4'h9, 4'hA);
    judge;
  endtask
  task stall_run;
    out_ready = 0;
    repeat (4) shift(4'hA, 4'h3);
    chk_n(stalls, 2);
    out_ready = 1;
    repeat (L) shift(4'h6, 4'h0);
    judge;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1;
    load_run;
    recirc_run;
    stall_run;
    end_sim;
  end
  // Watchdog well past the expected run length
  initial begin
    #400us;
    failures++;
    end_sim;
  end
endmodule // qdsr_top_bench
